// ===== verilog/acs_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
`include "acs_defs.svh"

// Functional notes
// - A window read on a bus path pops next FIFO word
// - Window serves data only on bus paths
// - Status bit 0 shows FIFO empty
// - Status bit 1 shows at least half full
// - Half full raises enabled interrupt requests
// - Status bit 2 shows FIFO full
// - Status bit 3 shows acquisition running
// - Storing starts at next frame boundary
// - Stopping finishes the current frame first
// - Writing bit 7 empties the FIFO
// - Bit 8 or bus reset resets board
// - Flags read-only, reset bits write-only
// - Internal source: control bit 0 gates acquisition
// - Control bit 1 selects sampling master
// - Control bit 2 picks trigger; slaves internal
// - Control bits 5..3 select output path
// - Unpacked MSB-justified; packed two 16-bit halves
// - Control bit 7 selects sampling clock
// - Undefined bits ignored, read as zero; control bit 6 reads back
// - Control register resets to zero fields
// - External acquire input is level sensitive
// - Control bit 8 sets oversampling ratio
// - Clock select resets to internal
module acs_ctrl #(
    parameter int DEPTH = 32768,
    parameter int AW = 15
) (
    input wire logic mclk, // Board clock, 10 MHz
    input wire logic nrst, // Hardware bus reset, active low
    input wire logic bus_sel, // One-cycle access strobe
    input wire logic bus_write, // 1 write, 0 read
    input wire logic [15:0] bus_addr, // Byte offset in board space
    input wire logic [31:0] bus_wdata, // Write data
    output logic [31:0] bus_rdata, // Read data
    output logic bus_ack, // Access done pulse
    input wire logic smp_valid, // Converter sample present
    output logic smp_ready, // Sample path can accept
    input wire logic [23:0] smp_data, // Signed sample
    input wire logic smp_first, // Sample is channel 0
    input wire logic smp_last, // Sample ends its frame
    input wire logic external_acquire_input, // Trigger pin level
    output logic irq_bus, // Bus interrupt request
    output logic irq_sec, // Secondary-bus interrupt request
    output logic sec_bus_en, // Secondary-bus interface enable
    output logic sampling_master, // Board is sampling master
    output logic clk_external, // External sampling clock chosen
    output logic osr_128, // Oversampling 128x chosen
    output logic [2:0] out_path // Selected output path
);

    typedef struct packed {
        acs_pkg::acs_state_e st;
        logic [15:0] control_reg;
        logic [AW:0] wptr;
        logic [AW:0] rptr;
        logic hold_v;
        logic [15:0] hold;
        logic s1;
        logic s2;
        logic s3;
        logic ext_lvl;
        logic [31:0] rdata;
        logic ack;
        logic irq_bus;
        logic irq_sec;
        logic sec_en;
    } acs_ctrl_s;

    acs_ctrl_s q;
    acs_ctrl_s next_q;
    logic [31:0] mem [0:DEPTH-1];
    logic mem_we;
    logic [31:0] mem_wd;
    logic [AW:0] count;
    logic empty;
    logic half;
    logic full;
    logic acq_en;
    logic packed_mode;
    logic bus_path;
    logic buf_valid;
    logic buf_ready;
    logic [`ACS_SMP_W-1:0] buf_data;
    logic take;
    logic clr_buf;

    initial
    begin
        if (DEPTH != (1 << AW) || AW < 2)
            $error("acs_ctrl: DEPTH must equal 2**AW, AW >= 2");
    end

    acs_skid #(
        .W(`ACS_SMP_W)
    ) u_skid (
        .mclk(mclk),
        .nrst(nrst),
        .clr(clr_buf),
        .in_valid(smp_valid),
        .in_ready(smp_ready),
        .in_data({smp_first, smp_last, smp_data}),
        .out_valid(buf_valid),
        .out_ready(buf_ready),
        .out_data(buf_data)
    );

    assign count = q.wptr - q.rptr;
    assign empty = (count == '0);
    assign full = (count == (AW+1)'(DEPTH));
    assign half = (count >= (AW+1)'(DEPTH / 2));
    // Slaves follow the software bit whatever the source field holds
    assign acq_en = (q.control_reg[`ACS_CR_MASTER]
                     & q.control_reg[`ACS_CR_SRC])
                    ? q.ext_lvl
                    : q.control_reg[`ACS_CR_ACQ];
    assign packed_mode = ~q.control_reg[`ACS_CR_PATH_MID]
                         & ~q.control_reg[`ACS_CR_PATH_HI];
    assign bus_path = ~q.control_reg[`ACS_CR_PATH_LO]
                      & ~q.control_reg[`ACS_CR_PATH_HI];
    // Once armed, a full FIFO stalls the buffer; idle samples drain away
    assign buf_ready = (q.st == acs_pkg::ACS_IDLE) | ~full;
    assign take = buf_valid & buf_ready;
    assign clr_buf = bus_sel & bus_write & (bus_addr == `ACS_ADDR_SR)
                     & bus_wdata[`ACS_SR_BRDRST];

    assign bus_rdata = q.rdata;
    assign bus_ack = q.ack;
    assign irq_bus = q.irq_bus;
    assign irq_sec = q.irq_sec;
    assign sec_bus_en = q.sec_en;
    assign sampling_master = q.control_reg[`ACS_CR_MASTER];
    assign clk_external = q.control_reg[`ACS_CR_CLKSEL];
    assign osr_128 = q.control_reg[`ACS_CR_OSR];
    assign out_path = q.control_reg[`ACS_CR_PATH_HI:`ACS_CR_PATH_LO];

    always_comb
    begin
        logic store;
        store = 1'b0;
        next_q = q;
        mem_we = 1'b0;
        mem_wd = '0;
        next_q.ack = 1'b0;

        // Trigger pin: three stages, a change counts when last two agree
        next_q.s1 = external_acquire_input;
        next_q.s2 = q.s1;
        next_q.s3 = q.s2;
        if (q.s2 == q.s3)
            next_q.ext_lvl = q.s3;

        case (q.st)
            acs_pkg::ACS_IDLE:
            begin
                if (acq_en)
                    next_q.st = acs_pkg::ACS_WAIT;
            end
            acs_pkg::ACS_WAIT:
            begin
                if (!acq_en)
                    next_q.st = acs_pkg::ACS_IDLE;
                else if (take && buf_data[`ACS_SMP_FIRST])
                begin
                    store = 1'b1;
                    next_q.st = acs_pkg::ACS_RUN;
                end
            end
            acs_pkg::ACS_RUN:
            begin
                if (take)
                begin
                    store = 1'b1;
                    if (buf_data[`ACS_SMP_LAST] && !acq_en)
                        next_q.st = acs_pkg::ACS_IDLE;
                end
            end
            default:
            begin
                next_q.st = acs_pkg::ACS_IDLE;
            end
        endcase

        if (store)
        begin
            if (packed_mode)
            begin
                if (!q.hold_v)
                begin
                    next_q.hold = buf_data[`ACS_PACK_HI:`ACS_PACK_LO];
                    next_q.hold_v = 1'b1;
                end
                else
                begin
                    mem_we = 1'b1;
                    mem_wd = {q.hold,
                              buf_data[`ACS_PACK_HI:`ACS_PACK_LO]};
                    next_q.hold_v = 1'b0;
                end
            end
            else
            begin
                mem_we = 1'b1;
                mem_wd = {buf_data[23:0], 8'h00};
            end
            if (mem_we)
                next_q.wptr = q.wptr + 1'b1;
        end

        if (bus_sel)
        begin
            next_q.ack = 1'b1;
            next_q.rdata = '0;
            if (bus_write)
            begin
                if (bus_addr == `ACS_ADDR_CR)
                begin
                    next_q.control_reg = bus_wdata[15:0]
                                         & `ACS_CR_MASK;
                    if (bus_wdata[`ACS_CR_PATH_LO]
                        && !bus_wdata[`ACS_CR_PATH_HI])
                        next_q.sec_en = 1'b1;
                end
                else if (bus_addr == `ACS_ADDR_SR)
                begin
                    if (bus_wdata[`ACS_SR_FIFORST])
                    begin
                        mem_we = 1'b0;
                        next_q.wptr = '0;
                        next_q.rptr = '0;
                        next_q.hold_v = 1'b0;
                    end
                    if (bus_wdata[`ACS_SR_BRDRST])
                    begin
                        mem_we = 1'b0;
                        next_q.wptr = '0;
                        next_q.rptr = '0;
                        next_q.hold_v = 1'b0;
                        next_q.control_reg = `ACS_CR_RESET;
                        next_q.st = acs_pkg::ACS_IDLE;
                        next_q.sec_en = 1'b0;
                    end
                end
            end
            else if (bus_addr < `ACS_WIN_END)
            begin
                // Offset inside the window is ignored
                if (bus_path && !empty)
                begin
                    next_q.rdata = mem[q.rptr[AW-1:0]];
                    next_q.rptr = q.rptr + 1'b1;
                end
            end
            else if (bus_addr == `ACS_ADDR_SR)
            begin
                next_q.rdata[`ACS_SR_EMPTY] = empty;
                next_q.rdata[`ACS_SR_HALF] = half;
                next_q.rdata[`ACS_SR_FULL] = full;
                next_q.rdata[`ACS_SR_RUN] =
                    (q.st == acs_pkg::ACS_RUN);
            end
            else if (bus_addr == `ACS_ADDR_CR)
            begin
                next_q.rdata[15:0] = q.control_reg;
            end
        end

        next_q.irq_bus = half & q.control_reg[`ACS_CR_BUSIRQ];
        next_q.irq_sec = half & q.control_reg[`ACS_CR_SECIRQ];
    end

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            q <= '0;
            q.st <= acs_pkg::ACS_IDLE;
            q.control_reg <= `ACS_CR_RESET;
        end
        else
        begin
            q <= next_q;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (mem_we)
            mem[q.wptr[AW-1:0]] <= mem_wd;
    end

endmodule : acs_ctrl

`default_nettype wire

// ===== verilog/acs_defs.svh
`ifndef ACS_DEFS_SVH
`define ACS_DEFS_SVH

// Register byte addresses on the host port
`define ACS_WIN_END 16'hfe00
`define ACS_ADDR_SR 16'hfe00
`define ACS_ADDR_CR 16'hfe04

// Control register fields
`define ACS_CR_ACQ 0
`define ACS_CR_MASTER 1
`define ACS_CR_SRC 2
`define ACS_CR_PATH_LO 3
`define ACS_CR_PATH_MID 4
`define ACS_CR_PATH_HI 5
`define ACS_CR_CLKSEL 7
`define ACS_CR_OSR 8
`define ACS_CR_SECIRQ 14
`define ACS_CR_BUSIRQ 15
`define ACS_CR_MASK 16'hc1ff
`define ACS_CR_RESET 16'h0000

// Status/reset register fields
`define ACS_SR_EMPTY 0
`define ACS_SR_HALF 1
`define ACS_SR_FULL 2
`define ACS_SR_RUN 3
`define ACS_SR_FIFORST 7
`define ACS_SR_BRDRST 8

// Sample word layout through the input buffer
`define ACS_SMP_W 26
`define ACS_SMP_FIRST 25
`define ACS_SMP_LAST 24
`define ACS_PACK_HI 23
`define ACS_PACK_LO 8

`endif

// ===== verilog/acs_pkg.sv
package acs_pkg;

    typedef enum logic [2:0] {
        ACS_IDLE = 3'b001,
        ACS_WAIT = 3'b010,
        ACS_RUN = 3'b100
    } acs_state_e;

endpackage : acs_pkg

// ===== verilog/acs_skid.sv
`timescale 1ns/100ps
`default_nettype none

module acs_skid #(
    parameter int W = 26
) (
    input wire logic mclk, // Board clock
    input wire logic nrst, // Async reset, active low
    input wire logic clr, // Discard held words
    input wire logic in_valid, // Word offered
    output logic in_ready, // Room for a word
    input wire logic [W-1:0] in_data, // Offered word
    output logic out_valid, // Word available
    input wire logic out_ready, // Consumer takes word
    output logic [W-1:0] out_data // Oldest word
);

    typedef struct packed {
        logic [1:0] cnt;
        logic [W-1:0] d0;
        logic [W-1:0] d1;
    } acs_skid_s;

    acs_skid_s q;
    acs_skid_s next_q;
    logic push;
    logic pop;

    initial
    begin
        if (W < 1)
            $error("acs_skid: W must be positive");
    end

    assign in_ready = (q.cnt != 2'h2);
    assign out_valid = (q.cnt != 2'h0);
    assign out_data = q.d0;
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    always_comb
    begin
        next_q = q;
        if (pop)
        begin
            next_q.d0 = q.d1;
        end
        case ({push, pop})
            2'b10:
            begin
                if (q.cnt == 2'h0)
                    next_q.d0 = in_data;
                else
                    next_q.d1 = in_data;
                next_q.cnt = q.cnt + 2'h1;
            end
            2'b01:
            begin
                next_q.cnt = q.cnt - 2'h1;
            end
            2'b11:
            begin
                if (q.cnt == 2'h1)
                    next_q.d0 = in_data;
                else
                    next_q.d1 = in_data;
            end
            default:
            begin
                next_q.cnt = q.cnt;
            end
        endcase
        if (clr)
            next_q.cnt = 2'h0;
    end

    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
            q <= '0;
        else
            q <= next_q;
    end

endmodule : acs_skid

`default_nettype wire

// ===== bench/acs_ctrl_assertions.sv
`timescale 1ns/100ps
`default_nettype none
`include "acs_defs.svh"

module acs_ctrl_assertions #(
    parameter int DEPTH = 32768,
    parameter int AW = 15
) (
    input wire logic mclk, // Clock
    input wire logic nrst, // Reset
    input wire logic bus_sel, // Strobe
    input wire logic bus_write, // Write
    input wire logic [15:0] bus_addr, // Offset
    input wire logic [31:0] bus_wdata, // Wdata
    input wire logic [31:0] bus_rdata, // Rdata
    input wire logic bus_ack, // Done
    input wire logic irq_bus, // Bus irq
    input wire logic irq_sec, // Sec irq
    input wire logic sec_bus_en, // Sec enable
    input wire logic sampling_master, // Master
    input wire logic [2:0] out_path // Path
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!nrst);

    logic cw;
    logic sw;
    logic rd;
    assign cw = bus_sel && bus_write && bus_addr == `ACS_ADDR_CR;
    assign sw = bus_sel && bus_write && bus_addr == `ACS_ADDR_SR;
    assign rd = bus_sel && !bus_write;

    AST_ACK_ONE: assert property (bus_sel |=> bus_ack)
        else $error("no ack after access");
    AST_ACK_ONLY: assert property (!bus_sel |=> !bus_ack)
        else $error("ack without access");
    AST_IRQ_BUS: assert property (cw && !bus_wdata[15]
        |-> ##2 !irq_bus)
        else $error("bus irq while disabled");
    AST_IRQ_SEC: assert property (cw && !bus_wdata[14]
        |-> ##2 !irq_sec)
        else $error("sec irq while disabled");
    AST_MASTER: assert property (cw |=>
        sampling_master == $past(bus_wdata[1]))
        else $error("master bit not followed");
    AST_PATH: assert property (cw |=>
        out_path == $past(bus_wdata[5:3]))
        else $error("path field not followed");
    AST_BRD_RST: assert property (sw && bus_wdata[8] |=>
        (!sec_bus_en && out_path == 3'h0 && !sampling_master))
        else $error("board reset incomplete");
    AST_STS_RD: assert property (rd && bus_addr == `ACS_ADDR_SR |=>
        bus_rdata[31:4] == 28'h0)
        else $error("status reads reset bits");
    AST_WIN_OFF: assert property (rd && bus_addr < `ACS_WIN_END
        && (out_path[0] || out_path[2]) |=> bus_rdata == 32'h0)
        else $error("window data off bus path");
    AST_UNMAP: assert property (rd && bus_addr > `ACS_ADDR_CR
        |=> bus_rdata == 32'h0)
        else $error("unmapped read not zero");
endmodule : acs_ctrl_assertions

bind acs_ctrl acs_ctrl_assertions #(.DEPTH(DEPTH), .AW(AW)) acs_chk_inst (
    .mclk(mclk), .nrst(nrst), .bus_sel(bus_sel), .bus_write(bus_write),
    .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
    .bus_ack(bus_ack), .irq_bus(irq_bus), .irq_sec(irq_sec),
    .sec_bus_en(sec_bus_en), .sampling_master(sampling_master),
    .out_path(out_path)
);
`default_nettype wire

// ===== bench/acs_src_model.sv
`timescale 1ns/100ps
`default_nettype none

module acs_src_model (
    input wire logic mclk, // Clock
    input wire logic nrst, // Reset
    input wire logic run, // Offer samples
    input wire logic smp_ready, // Taken
    output logic smp_valid, // Present
    output logic [23:0] smp_data, // Value
    output logic smp_first, // Channel 0
    output logic smp_last // Last channel
);
    // Four channels a frame; each sample carries its running count
    logic [15:0] seq;
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
            seq <= 16'h0;
        else if (smp_valid && smp_ready)
            seq <= seq + 16'h1;
    end
    assign smp_valid = run;
    assign smp_data = run ? {seq, 8'h00} : {~seq, 8'h5a};
    assign smp_first = run ? seq[1:0] == 2'h0 : seq[0];
    assign smp_last = run ? seq[1:0] == 2'h3 : ~seq[0];
endmodule : acs_src_model
`default_nettype wire

// ===== bench/acs_ctrl_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "acs_defs.svh"

module acs_ctrl_tb_top;
    localparam logic [15:0] CTL = `ACS_ADDR_CR;
    localparam logic [15:0] STS = `ACS_ADDR_SR;
    logic mclk = 1'b0;
    logic nrst = 1'b1;
    logic bus_sel = 1'b0;
    logic bus_write = 1'b0;
    logic [15:0] bus_addr = 16'h0;
    logic [31:0] bus_wdata = 32'h0;
    logic ext = 1'b0;
    logic src_on = 1'b0;
    logic [31:0] bus_rdata, q;
    logic [23:0] smp_data;
    logic [2:0] out_path;
    logic bus_ack, smp_valid, smp_ready, smp_first, smp_last, irq_bus;
    logic irq_sec, sec_bus_en, sampling_master, clk_external, osr_128;
    int errors = 0;
    int comparisons = 0;
    int n;

    always #50 mclk = ~mclk;

    acs_ctrl #(.DEPTH(16), .AW(4)) acs_ctrl_inst (
        .mclk(mclk), .nrst(nrst), .bus_sel(bus_sel), .bus_write(bus_write),
        .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
        .bus_ack(bus_ack), .smp_valid(smp_valid), .smp_ready(smp_ready),
        .smp_data(smp_data), .smp_first(smp_first), .smp_last(smp_last),
        .external_acquire_input(ext), .irq_bus(irq_bus), .irq_sec(irq_sec),
        .sec_bus_en(sec_bus_en), .sampling_master(sampling_master),
        .clk_external(clk_external), .osr_128(osr_128), .out_path(out_path)
    );
    acs_src_model acs_src_model_inst (
        .mclk(mclk), .nrst(nrst), .run(src_on), .smp_ready(smp_ready),
        .smp_valid(smp_valid), .smp_data(smp_data), .smp_first(smp_first),
        .smp_last(smp_last)
    );

    task close_out;
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : close_out

    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e)
        begin
            errors++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // One-cycle strobe; answer lands one edge later
    task acc(input logic w, input logic [15:0] a, input logic [31:0] d);
        @(posedge mclk);
        #1;
        bus_sel = 1'b1;
        bus_write = w;
        bus_addr = a;
        bus_wdata = d;
        @(posedge mclk);
        #1;
        bus_sel = 1'b0;
        q = bus_rdata;
        chk("bus_ack", 32'h1, bus_ack);
        if (bus_ack !== 1'b1)
            close_out();
    endtask : acc

    task wait_run(input logic e);
        int k;
        k = 0;
        acc(1'b0, STS, 32'h0);
        while (q[3] !== e && k < 30)
        begin
            acc(1'b0, STS, 32'h0);
            k++;
        end
        chk("running", {31'h0, e}, {31'h0, q[3]});
        if (q[3] !== e)
            close_out();
    endtask : wait_run

    task drain(input logic pk);
        logic [15:0] s;
        int k;
        n = 0;
        s = 16'h0;
        for (k = 0; k < 40; k++)
        begin
            acc(1'b0, STS, 32'h0);
            if (q[0] === 1'b1)
                break;
            acc(1'b0, 16'(k * 260), 32'h0);
            if (n == 0)
                s = q[31:16];
            if (n == 0)
                chk("first_ch", 32'h0, {30'h0, s[1:0]});
            chk("word", pk ? {s, s + 16'h1} : {s, 16'h0}, q);
            s = s + (pk ? 16'h2 : 16'h1);
            n++;
        end
        chk("words", 32'h1, {31'h0, n > 0});
        chk("tail", 32'h0, 32'(pk ? (2 * n) % 4 : n % 4));
        chk("drained", 32'h1, {31'h0, k < 40});
        if (k >= 40)
            close_out();
    endtask : drain

    initial
    begin
        #1;
        nrst = 1'b0;
        repeat (6) @(posedge mclk);
        #1;
        nrst = 1'b1;
        src_on = 1'b1;
        acc(1'b0, CTL, 32'h0);
        chk("ctl_reset", 32'h0, q);
        acc(1'b0, STS, 32'h0);
        chk("sts_reset", 32'h1, q);
        acc(1'b0, 16'h0040, 32'h0);
        chk("empty_win", 32'h0, q);
        acc(1'b0, 16'hfe08, 32'h0);
        chk("unmapped", 32'h0, q);
        acc(1'b1, CTL, 32'hffff3f86);
        acc(1'b0, CTL, 32'h0);
        chk("ctl_mask", 32'h0186, q);
        chk("master", 32'h1, sampling_master);
        chk("clk_ext", 32'h1, clk_external);
        chk("osr", 32'h1, osr_128);
        acc(1'b1, STS, 32'h100);
        acc(1'b0, CTL, 32'h0);
        chk("ctl_brd", 32'h0, q);
        chk("clk_int", 32'h0, clk_external);
        for (int m = 0; m < 2; m++)
        begin
            acc(1'b1, CTL, m ? 32'h01 : 32'h11);
            wait_run(1'b1);
            acc(1'b1, CTL, m ? 32'h00 : 32'h10);
            wait_run(1'b0);
            drain(m == 1);
        end
        acc(1'b1, CTL, 32'h09);
        wait_run(1'b1);
        chk("sec_en", 32'h1, sec_bus_en);
        acc(1'b1, CTL, 32'h08);
        wait_run(1'b0);
        acc(1'b0, 16'h0000, 32'h0);
        chk("win_off", 32'h0, q);
        acc(1'b1, CTL, 32'h20);
        acc(1'b0, 16'h0100, 32'h0);
        chk("win_fpdp", 32'h0, q);
        acc(1'b1, STS, 32'h0);
        acc(1'b0, STS, 32'h0);
        chk("sts_kept", 32'h0, q);
        acc(1'b1, STS, 32'h80);
        acc(1'b0, STS, 32'h0);
        chk("fifo_rst", 32'h1, q);
        acc(1'b1, STS, 32'h100);
        chk("sec_off", 32'h0, sec_bus_en);
        ext = 1'b1;
        acc(1'b1, CTL, 32'h14);
        repeat (10) @(posedge mclk);
        acc(1'b0, STS, 32'h0);
        chk("slave_int", 32'h1, q);
        acc(1'b1, CTL, 32'h16);
        wait_run(1'b1);
        ext = 1'b0;
        wait_run(1'b0);
        acc(1'b1, STS, 32'h80);
        acc(1'b1, CTL, 32'hc011);
        repeat (40) @(posedge mclk);
        acc(1'b0, STS, 32'h0);
        chk("sts_full", 32'he, q);
        chk("irq_bus", 32'h1, irq_bus);
        chk("irq_sec", 32'h1, irq_sec);
        chk("stall", 32'h0, smp_ready);
        acc(1'b1, STS, 32'h100);
        acc(1'b0, STS, 32'h0);
        chk("brd_rst", 32'h1, q);
        chk("irq_off", 32'h0, irq_bus);
        close_out();
    end
endmodule : acs_ctrl_tb_top
`default_nettype wire
